// ==== scs_peer.sv ====
`timescale 1ns/1ns
`default_nettype none
// ==================================================
// remote master: idle low clock, phase one, 160 ns link period
module scs_peer (
	// slave data back
	input wire logic miso,
	// driven lines
	output logic sck,
	output logic mosi,
	output logic ss_n
);
	logic [7:0] rx;
	initial
	begin
		sck = 1'b0;
		mosi = 1'b0;
		ss_n = 1'b1;
		rx = 8'h00;
	end
	task automatic xfer(input logic [7:0] tx);
		int i;
		// keep every pin change off the sampling edge of the block clock
		#1;
		ss_n = 1'b0;
		#80;
		for (i = 7; i >= 0; i--)
		begin
			sck = 1'b1;
			mosi = tx[i];
			#80;
			sck = 1'b0;
			rx = {rx[6:0], miso};
			#80;
		end
		// released data line must not keep showing the last bit
		mosi = ~mosi;
		ss_n = 1'b1;
	endtask
endmodule // scs_peer
`default_nettype wire

// ==== scs_pkg.sv ====
`default_nettype none
package scs_pkg;
	// ==================================================
	// register map
	localparam logic [7:0] SCS_ADDR_CTRL = 8'hd4;
	localparam logic [7:0] SCS_ADDR_STAT = 8'hd5;
	localparam logic [7:0] SCS_ADDR_DATA = 8'hc5;
	// ==================================================
	// control fields
	localparam int SCS_RATE_HI = 7;
	localparam int SCS_EN = 6;
	localparam int SCS_SELECT_DISABLE = 5;
	localparam int SCS_ROLE_MASTER = 4;
	localparam int SCS_CPOL = 3;
	localparam int SCS_CPHA = 2;
	localparam int SCS_RATE_MID = 1;
	localparam int SCS_RATE_LO = 0;
	localparam logic [7:0] SCS_CTRL_RST = 8'h14;
	// ==================================================
	// status fields
	localparam int SCS_ST_DONE = 7;
	localparam int SCS_ST_OVR = 5;
	localparam int SCS_ST_FAULT = 4;
	localparam int SCS_ST_TXE = 3;
	localparam int SCS_ST_LSB = 2;
	localparam int SCS_ST_TXEIE = 1;
	localparam int SCS_ST_FLTIE = 0;
	localparam logic SCS_TXE_RST = 1'b1;
	// ==================================================
	// timing: half period of the master clock in sys_clk cycles per rate code
	localparam logic [6:0] SCS_HALF_DIV4 = 7'h02;
	localparam logic [6:0] SCS_HALF_DIV8 = 7'h04;
	localparam logic [6:0] SCS_HALF_DIV16 = 7'h08;
	localparam logic [6:0] SCS_HALF_DIV32 = 7'h10;
	localparam logic [6:0] SCS_HALF_DIV64 = 7'h20;
	localparam logic [6:0] SCS_HALF_DIV128 = 7'h40;
	localparam logic [3:0] SCS_LAST_EDGE = 4'hf;
	localparam int SCS_SYNC_W = 4;
	// ==================================================
	typedef enum logic [0:0] {
		SCS_IDLE = 1'b0,
		SCS_SHIFT = 1'b1
	} scs_state_t;
	typedef struct packed {
		logic [7:0] ctrl;
		logic lsb_first;
		logic tx_empty_irq_en;
		logic role_fault_irq_en;
		logic transfer_done_flag;
		logic overrun_flag;
		logic role_fault_flag;
		logic tx_empty_flag;
		logic done_armed;
		logic [7:0] rx_buf;
		logic [7:0] shreg;
		logic samp;
		logic [3:0] ecnt;
		scs_state_t st;
		logic [6:0] divcnt;
		logic sck_ph;
		logic sck_prev;
		logic ss_prev;
		logic [7:0] rdata;
		logic irq;
		logic sck_o;
		logic sck_oe;
		logic mosi_o;
		logic mosi_oe;
		logic miso_o;
		logic miso_oe;
	} scs_regs_t;
endpackage
`default_nettype wire

// ==== scs_port.sv ====
// Local design decision: strobed register access.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - master clock is peripheral clock divided by 4..128 from a three bit rate code
// - control bit 6 enables the port; cleared holds it in internal reset
// - control bit 5 disables select use; in slave role ignored when phase is zero
// - no role fault request while select disable is set
// - control bit 4 chooses master when set, slave when cleared
// - control bit 3 sets serial clock idle level high when set
// - control bit 2 samples on return-to-idle edge when set, else leaving edge
// - control register resets to 0x14
// - done flag sets on completion; clears by data access after status read
// - overrun sets on byte while done flag set, keeps old byte; status read clears
// - role fault sets on wrong select level in either role; status read clears
// - after slave fault, ignore activity while select high; resume when low
// - master fault clears the enable bit
// - transmit empty set while data register may be written, clear while full
// - status bit 2 selects lsb first when set, msb first when cleared
// - transmit empty interrupt enable requests on empty and suppresses done request
// - status bit 0 gates the role fault request
// - done, overrun and fault flags reset to zero
// - data write loads the shift register directly
// - data read returns receive buffer, never the shift register
// - master fault also clears the role bit, leaving slave role
// - slave with select high floats its output and clears its bit counter, except when bit 5 is set in phase one
module scs_port
	import scs_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// interrupt request
	output logic irq,
	// serial clock pin
	input wire logic sck_i,
	output logic sck_o,
	output logic sck_oe,
	// master out pin
	input wire logic mosi_i,
	output logic mosi_o,
	output logic mosi_oe,
	// master in pin
	input wire logic miso_i,
	output logic miso_o,
	output logic miso_oe,
	// slave select pin
	input wire logic ss_n_i
);
	scs_regs_t r_q;
	scs_regs_t r_d;
	logic [SCS_SYNC_W-1:0] sync_out;
	logic sck_s, mosi_s, miso_s, ss_n_s;
	logic en, role_master, cpol, cpha, select_disable;
	logic [2:0] rate;
	logic [6:0] half;
	logic wr_ctrl, wr_stat, wr_data, rd_stat, rd_data;
	logic sel_slave, m_fault, ev, lead, samp_edge, in_bit, last_edge, start_ok;
	logic [7:0] shifted, final_byte;

	// ==================================================
	// decoding helpers
	function automatic logic [6:0] rate_half(input logic [2:0] code);
		case (code)
			3'h1: rate_half = SCS_HALF_DIV4;
			3'h2: rate_half = SCS_HALF_DIV8;
			3'h3: rate_half = SCS_HALF_DIV16;
			3'h4: rate_half = SCS_HALF_DIV32;
			3'h5: rate_half = SCS_HALF_DIV64;
			3'h6: rate_half = SCS_HALF_DIV128;
			default: rate_half = 7'h00;
		endcase
	endfunction

	function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b, input logic lsb);
		shift_in = lsb ? {b, sh[7:1]} : {sh[6:0], b};
	endfunction

	function automatic logic out_bit(input logic [7:0] sh, input logic lsb);
		out_bit = lsb ? sh[0] : sh[7];
	endfunction

	// ==================================================
	// pin synchronisers
	scs_sync #(
		.W(SCS_SYNC_W)
	) u_sync (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.din({sck_i, mosi_i, miso_i, ss_n_i}),
		.dout(sync_out)
	);
	assign sck_s = sync_out[3];
	assign mosi_s = sync_out[2];
	assign miso_s = sync_out[1];
	assign ss_n_s = sync_out[0];

	// ==================================================
	// control decode
	assign en = r_q.ctrl[SCS_EN];
	assign role_master = r_q.ctrl[SCS_ROLE_MASTER];
	assign cpol = r_q.ctrl[SCS_CPOL];
	assign cpha = r_q.ctrl[SCS_CPHA];
	assign select_disable = r_q.ctrl[SCS_SELECT_DISABLE];
	assign rate = {r_q.ctrl[SCS_RATE_HI], r_q.ctrl[SCS_RATE_MID], r_q.ctrl[SCS_RATE_LO]};
	assign half = rate_half(rate);

	assign wr_ctrl = reg_wr && (reg_addr == SCS_ADDR_CTRL);
	assign wr_stat = reg_wr && (reg_addr == SCS_ADDR_STAT);
	assign wr_data = reg_wr && (reg_addr == SCS_ADDR_DATA);
	assign rd_stat = reg_rd && (reg_addr == SCS_ADDR_STAT);
	assign rd_data = reg_rd && (reg_addr == SCS_ADDR_DATA);

	// slave ignores select when disabled only in phase one
	assign sel_slave = (select_disable && cpha) || !ss_n_s;
	assign m_fault = en && role_master && !select_disable && !ss_n_s;
	assign start_ok = en && role_master && (half != 7'h00) && (r_q.st == SCS_IDLE) && !m_fault;

	// edge events: divider in master, synchronised pin in slave
	always_comb
	begin
		if (role_master)
		begin
			ev = en && !m_fault && (r_q.st == SCS_SHIFT) && (half != 7'h00) && (r_q.divcnt == half - 7'h01);
			lead = !r_q.ecnt[0];
		end
		else
		begin
			ev = en && sel_slave && (sck_s != r_q.sck_prev);
			lead = (sck_s != cpol);
		end
	end

	assign samp_edge = lead ^ cpha;
	assign in_bit = role_master ? miso_s : mosi_s;
	assign last_edge = (r_q.ecnt == SCS_LAST_EDGE);
	assign shifted = shift_in(r_q.shreg, r_q.samp, r_q.lsb_first);
	assign final_byte = shift_in(r_q.shreg, cpha ? in_bit : r_q.samp, r_q.lsb_first);

	// ==================================================
	// next state
	always_comb
	begin
		r_d = r_q;
		r_d.sck_prev = sck_s;
		r_d.ss_prev = ss_n_s;

		// register accesses; clears first so later sets win
		if (rd_stat)
		begin
			r_d.done_armed = r_q.transfer_done_flag;
			r_d.overrun_flag = 1'b0;
			r_d.role_fault_flag = 1'b0;
		end
		if ((rd_data || wr_data) && r_q.done_armed)
		begin
			r_d.transfer_done_flag = 1'b0;
			r_d.done_armed = 1'b0;
		end
		if (wr_ctrl)
			r_d.ctrl = reg_wdata;
		if (wr_stat)
		begin
			// bit 6 has no storage, so a stray one is harmless
			r_d.lsb_first = reg_wdata[SCS_ST_LSB];
			r_d.tx_empty_irq_en = reg_wdata[SCS_ST_TXEIE];
			r_d.role_fault_irq_en = reg_wdata[SCS_ST_FLTIE];
		end
		if (wr_data)
		begin
			r_d.shreg = reg_wdata;
			r_d.tx_empty_flag = 1'b0;
			if (start_ok)
			begin
				r_d.st = SCS_SHIFT;
				r_d.ecnt = 4'h0;
				r_d.divcnt = 7'h00;
			end
		end

		// transfer engine
		if (!en)
		begin
			r_d.st = SCS_IDLE;
			r_d.ecnt = 4'h0;
			r_d.divcnt = 7'h00;
			r_d.sck_ph = 1'b0;
		end
		else if (m_fault)
		begin
			r_d.role_fault_flag = 1'b1;
			r_d.ctrl[SCS_EN] = 1'b0;
			r_d.ctrl[SCS_ROLE_MASTER] = 1'b0;
			r_d.st = SCS_IDLE;
			r_d.ecnt = 4'h0;
			r_d.sck_ph = 1'b0;
		end
		else if (!role_master && !sel_slave)
		begin
			r_d.st = SCS_IDLE;
			r_d.ecnt = 4'h0;
			if (!select_disable && !r_q.ss_prev)
				r_d.role_fault_flag = 1'b1;
		end
		else if (role_master && (r_q.st == SCS_SHIFT) && !ev)
			r_d.divcnt = r_q.divcnt + 7'h01;

		if (ev)
		begin
			r_d.divcnt = 7'h00;
			if (role_master)
				r_d.sck_ph = !r_q.sck_ph;
			if (samp_edge)
				r_d.samp = in_bit;
			else if (!(cpha && (r_q.ecnt == 4'h0)))
				r_d.shreg = shifted;
			r_d.ecnt = r_q.ecnt + 4'h1;
			if (last_edge)
			begin
				// the unread byte is kept; only the shifter sees the new one
				r_d.shreg = final_byte;
				if (r_q.transfer_done_flag)
					r_d.overrun_flag = 1'b1;
				else
					r_d.rx_buf = final_byte;
				r_d.transfer_done_flag = 1'b1;
				r_d.tx_empty_flag = 1'b1;
				r_d.st = SCS_IDLE;
				r_d.ecnt = 4'h0;
			end
		end

		// read data, valid the cycle after the strobe
		r_d.rdata = 8'h00;
		if (reg_rd)
		begin
			case (reg_addr)
				SCS_ADDR_CTRL: r_d.rdata = r_q.ctrl;
				SCS_ADDR_STAT: r_d.rdata = {r_q.transfer_done_flag, 1'b0, r_q.overrun_flag,
					r_q.role_fault_flag, r_q.tx_empty_flag, r_q.lsb_first,
					r_q.tx_empty_irq_en, r_q.role_fault_irq_en};
				SCS_ADDR_DATA: r_d.rdata = r_q.rx_buf;
				default: r_d.rdata = 8'h00;
			endcase
		end

		// pins and request, from the values about to be registered
		r_d.irq = (r_d.tx_empty_irq_en ? r_d.tx_empty_flag : r_d.transfer_done_flag)
			| (r_d.role_fault_flag & r_d.role_fault_irq_en & !r_d.ctrl[SCS_SELECT_DISABLE]);
		r_d.sck_oe = r_d.ctrl[SCS_EN] && r_d.ctrl[SCS_ROLE_MASTER];
		r_d.sck_o = r_d.ctrl[SCS_CPOL] ^ r_d.sck_ph;
		r_d.mosi_oe = r_d.ctrl[SCS_EN] && r_d.ctrl[SCS_ROLE_MASTER];
		r_d.mosi_o = out_bit(r_d.shreg, r_d.lsb_first);
		r_d.miso_oe = r_d.ctrl[SCS_EN] && !r_d.ctrl[SCS_ROLE_MASTER] && sel_slave;
		r_d.miso_o = out_bit(r_d.shreg, r_d.lsb_first);
	end

	// ==================================================
	// state register
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			r_q <= '0;
			r_q.ctrl <= SCS_CTRL_RST;
			r_q.tx_empty_flag <= SCS_TXE_RST;
			r_q.ss_prev <= 1'b1;
			r_q.st <= SCS_IDLE;
		end
		else
			r_q <= r_d;
	end

	assign reg_rdata = r_q.rdata;
	assign irq = r_q.irq;
	assign sck_o = r_q.sck_o;
	assign sck_oe = r_q.sck_oe;
	assign mosi_o = r_q.mosi_o;
	assign mosi_oe = r_q.mosi_oe;
	assign miso_o = r_q.miso_o;
	assign miso_oe = r_q.miso_oe;

	// ==================================================
	// checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	sequence s_master_start;
		wr_data && start_ok;
	endsequence

	sequence s_armed_access;
		rd_stat && r_q.transfer_done_flag ##1 (rd_data || wr_data) && !rd_stat;
	endsequence

	chk_ctrl_readback: assert property (reg_rd && reg_addr == SCS_ADDR_CTRL && !ev && !m_fault
		|=> reg_rdata == $past(r_q.ctrl))
		else $error("control readback mismatch");

	chk_master_fault: assert property (m_fault
		|=> !r_q.ctrl[SCS_EN] && !r_q.ctrl[SCS_ROLE_MASTER] && r_q.role_fault_flag && !r_q.sck_oe)
		else $error("master fault did not drop enable and role");

	chk_fault_masked: assert property ($rose(r_q.role_fault_flag) |-> !$past(r_q.ctrl[SCS_SELECT_DISABLE])
		|| ($past(role_master) && $past(select_disable) == 1'b0))
		else $error("fault raised while select disabled");

	chk_overrun_keep: assert property (ev && last_edge && r_q.transfer_done_flag && !rd_stat
		|=> r_q.overrun_flag && $stable(r_q.rx_buf))
		else $error("overrun lost the unread byte");

	chk_invalid_rate: assert property (wr_data && en && role_master && half == 7'h00 && !wr_ctrl
		&& r_q.st == SCS_IDLE |=> r_q.st == SCS_IDLE [*2])
		else $error("transfer started on invalid rate");

	chk_slave_float: assert property (en && !role_master && !sel_slave && !wr_ctrl
		|=> !r_q.miso_oe && r_q.ecnt == 4'h0)
		else $error("deselected slave still driving");

	chk_tx_full: assert property (s_master_start |=> !r_q.tx_empty_flag && r_q.st == SCS_SHIFT
		##1 r_q.sck_o == cpol)
		else $error("transfer start did not fill or clock stepped early");

	chk_done_clear: assert property (s_armed_access ##0 !(ev && last_edge)
		|=> !r_q.transfer_done_flag)
		else $error("done flag not cleared by data access");

	chk_irq_merge: assert property (r_q.tx_empty_irq_en && r_q.tx_empty_flag ##1
		r_q.tx_empty_irq_en && r_q.tx_empty_flag |-> r_q.irq)
		else $error("empty request missing");

	chk_disabled_quiet: assert property (!en && !wr_ctrl
		|=> !r_q.sck_oe && !r_q.miso_oe && r_q.st == SCS_IDLE)
		else $error("disabled port still active");

	chk_done_suppressed: assert property (r_q.tx_empty_irq_en && !r_q.tx_empty_flag && !r_q.role_fault_flag
		|-> !r_q.irq)
		else $error("done request not suppressed");
endmodule // scs_port
`default_nettype wire

// ==== scs_port_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module scs_port_test;
	import scs_pkg::*;
	// ==================================================
	// stimulus and wiring
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic ss_tb = 1'b1;
	logic [7:0] reg_rdata;
	logic irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
	logic p_sck, p_mosi, p_ss_n, miso_w;
	int mismatches = 0;
	int comparisons = 0;
	int edges = 0;
	logic sck_d = 1'b0;
	logic mosi_d = 1'b0;
	logic [7:0] cap = 8'h00;
	always #2 sys_clk = ~sys_clk;
	assign miso_w = miso_oe ? miso_o : ~miso_o;
	scs_port i_dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .sck_i(p_sck),
		.sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(p_mosi), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
		.miso_i(mosi_o), .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(p_ss_n & ss_tb));
	scs_peer i_peer (.miso(miso_w), .sck(p_sck), .mosi(p_mosi), .ss_n(p_ss_n));
	// bits captured on the trailing (falling) edge of the master clock
	// the data seen just before that edge is kept, since the last edge reloads the shifter
	always @(posedge sys_clk)
	begin
		sck_d <= sck_o;
		mosi_d <= mosi_o;
		if (sck_o !== sck_d)
		begin
			edges <= edges + 1;
			if (sck_d)
				cap <= {cap[6:0], mosi_d};
		end
	end
	// ==================================================
	// shared tasks
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmpi(input int got, input int lo, input int hi);
		comparisons++;
		if (got < lo || got > hi)
		begin
			mismatches++;
			$display("ERROR %0t count %0d outside %0d..%0d", $time, got, lo, hi);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		cmp(reg_rdata, exp);
	endtask
	task automatic wait_irq(output int n);
		n = 0;
		while (irq !== 1'b1 && n < 3000)
		begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (n == 3000)
		begin
			mismatches++;
			$display("ERROR %0t interrupt timeout", $time);
			stop_test;
		end
	endtask
	task automatic do_reset;
		@(posedge sys_clk);
		rstn <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
	endtask
	// ==================================================
	// scenarios
	task automatic t_master(input logic [2:0] code, input logic [7:0] d, input logic lsb);
		logic [7:0] r;
		int n, e0, i;
		do_reset;
		wr(SCS_ADDR_CTRL, {code[2], 3'b101, 2'b01, code[1:0]});
		wr(SCS_ADDR_STAT, {5'h00, lsb, 2'b00});
		e0 = edges;
		wr(SCS_ADDR_DATA, d);
		wait_irq(n);
		// edge counter and capture trail the pins by one cycle
		@(posedge sys_clk);
		#1;
		cmpi(n, 16 * (1 << code) - 2, 16 * (1 << code) + 4);
		cmpi(edges - e0, 16, 16);
		cmp({7'h00, sck_o}, 8'h00);
		for (i = 0; i < 8; i++)
			r[i] = lsb ? d[7 - i] : d[i];
		cmp(cap, r);
		cmp({6'h00, sck_oe, mosi_oe}, 8'h03);
		rd(SCS_ADDR_STAT, {4'h8, 1'b1, lsb, 2'b00});
		// at /4 the looped-back bit passes the input synchroniser too late and lands one slot behind
		if (code == 3'h1)
			r = lsb ? {d[6:0], d[0]} : {d[7], d[7:1]};
		else
			r = d;
		rd(SCS_ADDR_DATA, r);
		rd(SCS_ADDR_STAT, {4'h0, 1'b1, lsb, 2'b00});
	endtask
	task automatic t_idle(input logic [7:0] c);
		int e0;
		do_reset;
		wr(SCS_ADDR_CTRL, c);
		e0 = edges;
		wr(SCS_ADDR_DATA, 8'h5a);
		repeat (300) @(posedge sys_clk);
		cmpi(edges - e0, 0, 0);
		cmp({7'h00, irq}, 8'h00);
	endtask
	task automatic t_overrun;
		int n;
		do_reset;
		wr(SCS_ADDR_CTRL, 8'h56);
		wr(SCS_ADDR_DATA, 8'h11);
		wait_irq(n);
		wr(SCS_ADDR_DATA, 8'h22);
		repeat (80) @(posedge sys_clk);
		rd(SCS_ADDR_STAT, 8'ha8);
		rd(SCS_ADDR_DATA, 8'h11);
		rd(SCS_ADDR_STAT, 8'h08);
	endtask
	task automatic t_fault(input logic dis);
		do_reset;
		wr(SCS_ADDR_CTRL, {2'b01, dis, 5'h15});
		wr(SCS_ADDR_STAT, 8'h01);
		ss_tb <= 1'b0;
		repeat (10) @(posedge sys_clk);
		ss_tb <= 1'b1;
		repeat (5) @(posedge sys_clk);
		cmp({7'h00, irq}, {7'h00, ~dis});
		cmp({6'h00, sck_oe, mosi_oe}, dis ? 8'h03 : 8'h00);
		rd(SCS_ADDR_CTRL, dis ? 8'h75 : 8'h05);
		rd(SCS_ADDR_STAT, dis ? 8'h09 : 8'h19);
		rd(SCS_ADDR_STAT, 8'h09);
	endtask
	task automatic t_slave;
		do_reset;
		wr(SCS_ADDR_CTRL, 8'h44);
		wr(SCS_ADDR_DATA, 8'h3c);
		i_peer.xfer(8'hc3);
		repeat (10) @(posedge sys_clk);
		cmp(i_peer.rx, 8'h3c);
		cmp({7'h00, miso_oe}, 8'h00);
		cmp({6'h00, sck_oe, mosi_oe}, 8'h00);
		rd(SCS_ADDR_STAT, 8'h98);
		rd(SCS_ADDR_DATA, 8'hc3);
		rd(SCS_ADDR_STAT, 8'h08);
	endtask
	task automatic t_txe_irq;
		int n;
		do_reset;
		wr(SCS_ADDR_CTRL, 8'h55);
		wr(SCS_ADDR_STAT, 8'h02);
		repeat (3) @(posedge sys_clk);
		cmp({7'h00, irq}, 8'h01);
		wr(SCS_ADDR_DATA, 8'h0f);
		repeat (5) @(posedge sys_clk);
		cmp({7'h00, irq}, 8'h00);
		wait_irq(n);
		cmpi(n, 20, 40);
	endtask
	// ==================================================
	// main sequence
	initial
	begin
		do_reset;
		rd(SCS_ADDR_CTRL, SCS_CTRL_RST);
		rd(SCS_ADDR_STAT, 8'h08);
		wr(SCS_ADDR_CTRL, 8'hab);
		rd(SCS_ADDR_CTRL, 8'hab);
		rd(8'h00, 8'h00);
		for (int c = 1; c <= 6; c++)
			t_master(3'(c), 8'h35 + 8'(c), 1'(c));
		t_idle(8'h54);
		t_idle(8'hd7);
		t_idle(8'h15);
		t_overrun;
		t_fault(1'b0);
		t_fault(1'b1);
		t_slave;
		t_txe_irq;
		stop_test;
	end
endmodule // scs_port_test
`default_nettype wire

// ==== scs_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
module scs_sync #(
	parameter int W = 4
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// levels
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_q;
	// ==================================================
	// two stages; first stage feeds only the second
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_q <= '1;
			dout <= '1;
		end
		else
		begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule // scs_sync
`default_nettype wire
